//--- rtl/pmc_consts.vh
// Constants for the programmable macrocell array: map, fields, reset values
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
`define PMC_CELLS 32
`define PMC_TERMS 5
`define PMC_ALL_TERMS 160
`define PMC_REGION_CELLS 16
`define PMC_CHAIN_CELLS 8
`define PMC_PD_CELL 31
`define PMC_SIG_W 85
`define PMC_PT_STRIDE 8
`define PMC_MASK_WORDS 1280
// Byte addresses of the register map; the mask base is a word address
`define PMC_ADDR_DEV 16'h0000
`define PMC_ADDR_STATUS 16'h0004
`define PMC_ADDR_STATE 16'h0008
`define PMC_ADDR_PINS 16'h000C
`define PMC_ADDR_CELL_LO 16'h0100
`define PMC_ADDR_CELL_HI 16'h01FC
`define PMC_ADDR_MASK_LO 16'h1000
`define PMC_ADDR_MASK_HI 16'h23FC
`define PMC_MASK_BASE_W 14'h0400
// Decoded regions
`define PMC_DEC_NONE 3'h0
`define PMC_DEC_DEV 3'h1
`define PMC_DEC_STATUS 3'h2
`define PMC_DEC_STATE 3'h3
`define PMC_DEC_PINS 3'h4
`define PMC_DEC_CELL 3'h5
`define PMC_DEC_MASK 3'h6
// Device configuration word
`define PMC_DEV_CLK_IDX 1:0
`define PMC_DEV_CLR_IDX 3:2
`define PMC_DEV_OE1_IDX 5:4
`define PMC_DEV_OE2_IDX 7:6
`define PMC_DEV_PD_EN 8
`define PMC_DEV_KEEP_EN 9
`define PMC_DEV_RESET 32'h0000_02E4
// Cell configuration word A
`define PMC_A_OR 4:0
`define PMC_A_CAS_EN 5
`define PMC_A_XOR_SEL 7:6
`define PMC_A_XOR_PT 10:8
`define PMC_A_D_SEL 11
`define PMC_A_D_PT 14:12
`define PMC_A_K_PT 17:15
`define PMC_A_MODE 20:18
`define PMC_A_CLK_SEL 21
`define PMC_A_CLK_PT 24:22
`define PMC_A_CE_EN 25
`define PMC_A_CE_PT 28:26
// Cell configuration word B
`define PMC_B_AR_SEL 1:0
`define PMC_B_AR_PT 4:2
`define PMC_B_AP_EN 5
`define PMC_B_AP_PT 8:6
`define PMC_B_OUT_REG 9
`define PMC_B_OE_SEL 12:10
`define PMC_B_OE_PT 15:13
`define PMC_B_FB_PT 18:16
`define PMC_CFG_RESET 32'h0000_0000
// Field encodings
`define PMC_XOR_LOW 2'h0
`define PMC_XOR_HIGH 2'h1
`define PMC_XOR_TERM 2'h2
`define PMC_AR_OFF 2'h0
`define PMC_AR_CLEAR 2'h1
`define PMC_AR_TERM 2'h2
`define PMC_AR_BOTH 2'h3
`define PMC_OE_OFF 3'h0
`define PMC_OE_ON 3'h1
`define PMC_OE_PIN1 3'h2
`define PMC_OE_PIN2 3'h3
`define PMC_OE_TERM 3'h4
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`endif

//--- rtl/pmc_device.v
// Programmable logic device: 32 macrocells, pin control and register access
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`include "pmc_consts.vh"
module pmc_device (
  input wire i_clk,
  input wire i_rst_n,
  input wire [15:0] i_axi_awaddr,
  input wire i_axi_awvalid,
  output reg o_axi_awready,
  input wire [31:0] i_axi_wdata,
  input wire [3:0] i_axi_wstrb,
  input wire i_axi_wvalid,
  output reg o_axi_wready,
  output reg [1:0] o_axi_bresp,
  output reg o_axi_bvalid,
  input wire i_axi_bready,
  input wire [15:0] i_axi_araddr,
  input wire i_axi_arvalid,
  output reg o_axi_arready,
  output reg [31:0] o_axi_rdata,
  output reg [1:0] o_axi_rresp,
  output reg o_axi_rvalid,
  input wire i_axi_rready,
  input wire [3:0] i_ded_pin,
  input wire [3:0] i_ded_driven,
  input wire i_power_down_pin,
  input wire [31:0] i_io_pin,
  input wire [31:0] i_io_driven,
  output reg [31:0] o_io_pin,
  output reg [31:0] o_io_oe_n,
  output reg o_power_down_active,
  output reg o_standby
);

  // Configuration storage
  reg [31:0] dev_cfg;
  reg [31:0] cell_a [0:31];
  reg [31:0] cell_b [0:31];
  reg [31:0] mask_mem [0:1279];

  // Pin synchronisers and held pin values
  // Layout: pd pin, ded driven, ded level, io driven, io level
  reg [72:0] sync1;
  reg [72:0] sync2;
  reg [31:0] io_val;
  reg [3:0] ded_val;
  reg pd_val;

  // Cell state
  reg [31:0] q;
  reg [31:0] clk_prev;
  reg [31:0] fb;
  reg [31:0] rbus;
  reg [67:0] act_snap;

  // AXI capture registers
  reg [15:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // Combinational cell results
  reg [159:0] pt_all;
  reg [95:0] tmask;
  reg [95:0] cmask;
  reg [84:0] sig;
  reg [4:0] terms;
  reg [31:0] ca;
  reg [31:0] cb;
  reg [31:0] cascade_out;
  reg [31:0] xo;
  reg [31:0] dval;
  reg [31:0] kval;
  reg [31:0] clk_lvl;
  reg [31:0] clk_edge;
  reg [31:0] ar;
  reg [31:0] ap;
  reg [31:0] oe_on;
  reg [31:0] fold;
  reg [31:0] pin_out;
  reg [31:0] next_q;
  reg [31:0] next_fb;
  reg [31:0] rd_mux;
  reg xor_in;
  reg cascade_in;
  integer c;
  integer p;
  integer t;
  integer k;
  integer i;
  integer j;

  wire frozen;
  wire [68:0] gbus;
  wire gclk;
  wire global_clear_n;
  wire output_enable_n_first;
  wire output_enable_n_second;
  wire wr_en;
  wire [2:0] wr_dec;
  wire [2:0] rd_dec;
  wire [13:0] wr_mi;
  wire [13:0] rd_mi;

  // Product term: low when any selected true or complement literal fails
  function pmc_term;
    input [84:0] tm;
    input [84:0] cm;
    input [84:0] s;
    begin
      pmc_term = ~|((tm & ~s) | (cm & s));
    end
  endfunction

  // Product term selector; codes above four pick nothing
  function pmc_pick;
    input [4:0] tv;
    input [2:0] idx;
    begin
      if (idx < 3'h5)
        pmc_pick = tv[idx];
      else
        pmc_pick = 1'b0;
    end
  endfunction

  // Byte-lane merge for register writes
  function [31:0] pmc_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      pmc_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          pmc_merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // Address decode shared by read and write paths
  function [2:0] pmc_decode;
    input [15:0] a;
    begin
      if (a == `PMC_ADDR_DEV)
        pmc_decode = `PMC_DEC_DEV;
      else if (a == `PMC_ADDR_STATUS)
        pmc_decode = `PMC_DEC_STATUS;
      else if (a == `PMC_ADDR_STATE)
        pmc_decode = `PMC_DEC_STATE;
      else if (a == `PMC_ADDR_PINS)
        pmc_decode = `PMC_DEC_PINS;
      else if (a >= `PMC_ADDR_CELL_LO && a <= `PMC_ADDR_CELL_HI)
        pmc_decode = `PMC_DEC_CELL;
      else if (a >= `PMC_ADDR_MASK_LO && a <= `PMC_ADDR_MASK_HI)
        pmc_decode = `PMC_DEC_MASK;
      else
        pmc_decode = `PMC_DEC_NONE;
    end
  endfunction

  // Power-down only when the option is configured
  assign frozen = dev_cfg[`PMC_DEV_PD_EN] & sync2[72];

  // Dedicated inputs mapped onto global control roles
  assign gclk = ded_val[dev_cfg[`PMC_DEV_CLK_IDX]];
  assign global_clear_n = ded_val[dev_cfg[`PMC_DEV_CLR_IDX]];
  assign output_enable_n_first = ded_val[dev_cfg[`PMC_DEV_OE1_IDX]];
  assign output_enable_n_second = ded_val[dev_cfg[`PMC_DEV_OE2_IDX]];

  // Global bus: power-down pin reads low once it is the power-down control
  assign gbus = {pd_val & ~dev_cfg[`PMC_DEV_PD_EN], ded_val, io_val, fb};

  assign wr_en = ~o_axi_awready & ~o_axi_wready & ~o_axi_bvalid;
  assign wr_dec = pmc_decode(awaddr_q);
  assign rd_dec = pmc_decode(i_axi_araddr);
  assign wr_mi = awaddr_q[15:2] - `PMC_MASK_BASE_W;
  assign rd_mi = i_axi_araddr[15:2] - `PMC_MASK_BASE_W;

  // Pin capture; two flops first because pins are asynchronous to i_clk
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1 <= 73'h0;
      sync2 <= 73'h0;
      io_val <= 32'h0000_0000;
      ded_val <= 4'h0;
      pd_val <= 1'b0;
    end
    else
    begin
      sync1 <= {i_power_down_pin, i_ded_driven, i_ded_pin, i_io_driven, i_io_pin};
      sync2 <= sync1;
      if (!frozen)
      begin
        pd_val <= sync2[72];
        for (i = 0; i < 32; i = i + 1)
          if (sync2[32 + i])
            io_val[i] <= sync2[i];
          else if (!dev_cfg[`PMC_DEV_KEEP_EN])
            io_val[i] <= 1'b0;
        for (i = 0; i < 4; i = i + 1)
          if (sync2[68 + i])
            ded_val[i] <= sync2[64 + i];
          else if (!dev_cfg[`PMC_DEV_KEEP_EN])
            ded_val[i] <= 1'b0;
      end
    end
  end

  // Product terms; regional part comes from registered foldbacks, no loops
  always @*
  begin
    pt_all = 160'h0;
    tmask = 96'h0;
    cmask = 96'h0;
    sig = 85'h0;
    for (p = 0; p < `PMC_CELLS; p = p + 1)
    begin
      sig = {rbus[(p / `PMC_REGION_CELLS) * 16 +: 16], gbus};
      for (t = 0; t < `PMC_TERMS; t = t + 1)
      begin
        k = (p * `PMC_TERMS + t) * `PMC_PT_STRIDE;
        tmask = {mask_mem[k + 2], mask_mem[k + 1], mask_mem[k]};
        cmask = {mask_mem[k + 5], mask_mem[k + 4], mask_mem[k + 3]};
        pt_all[p * `PMC_TERMS + t] = pmc_term(tmask[84:0], cmask[84:0], sig);
      end
    end
  end

  // Per-cell sum, polarity, storage and output logic
  always @*
  begin
    terms = 5'h0;
    ca = 32'h0000_0000;
    cb = 32'h0000_0000;
    cascade_out = 32'h0000_0000;
    xo = 32'h0000_0000;
    dval = 32'h0000_0000;
    kval = 32'h0000_0000;
    clk_lvl = 32'h0000_0000;
    clk_edge = 32'h0000_0000;
    ar = 32'h0000_0000;
    ap = 32'h0000_0000;
    oe_on = 32'h0000_0000;
    fold = 32'h0000_0000;
    pin_out = 32'h0000_0000;
    next_q = q;
    next_fb = fb;
    xor_in = 1'b0;
    cascade_in = 1'b0;
    for (c = 0; c < `PMC_CELLS; c = c + 1)
    begin
      terms = pt_all[c * `PMC_TERMS +: 5];
      ca = cell_a[c];
      cb = cell_b[c];
      // Chains break every eight cells, so one chain spans 40 terms
      if (c % `PMC_CHAIN_CELLS == 0)
        cascade_in = 1'b0;
      else
        cascade_in = cascade_out[c - 1];
      cascade_out[c] = |(terms & ca[`PMC_A_OR]) | (ca[`PMC_A_CAS_EN] & cascade_in);
      case (ca[`PMC_A_XOR_SEL])
        `PMC_XOR_LOW: xor_in = 1'b0;
        `PMC_XOR_HIGH: xor_in = 1'b1;
        `PMC_XOR_TERM: xor_in = pmc_pick(terms, ca[`PMC_A_XOR_PT]);
        default: xor_in = 1'b0;
      endcase
      xo[c] = cascade_out[c] ^ xor_in;
      dval[c] = ca[`PMC_A_D_SEL] ? pmc_pick(terms, ca[`PMC_A_D_PT]) : xo[c];
      kval[c] = pmc_pick(terms, ca[`PMC_A_K_PT]);
      clk_lvl[c] = ca[`PMC_A_CLK_SEL] ? pmc_pick(terms, ca[`PMC_A_CLK_PT]) : gclk;
      // Enable term only gates the pin clock
      clk_edge[c] = clk_lvl[c] & ~clk_prev[c] & (ca[`PMC_A_CLK_SEL] |
        ~ca[`PMC_A_CE_EN] | pmc_pick(terms, ca[`PMC_A_CE_PT]));
      case (cb[`PMC_B_AR_SEL])
        `PMC_AR_CLEAR: ar[c] = ~global_clear_n;
        `PMC_AR_TERM: ar[c] = pmc_pick(terms, cb[`PMC_B_AR_PT]);
        `PMC_AR_BOTH: ar[c] = ~global_clear_n | pmc_pick(terms, cb[`PMC_B_AR_PT]);
        default: ar[c] = 1'b0;
      endcase
      ap[c] = cb[`PMC_B_AP_EN] & pmc_pick(terms, cb[`PMC_B_AP_PT]);
      case (ca[`PMC_A_MODE])
        3'h0: next_q[c] = clk_edge[c] ? dval[c] : q[c];
        3'h1: next_q[c] = (clk_edge[c] & dval[c]) ? ~q[c] : q[c];
        3'h2:
        begin
          if (clk_edge[c])
            next_q[c] = (dval[c] & ~q[c]) | (~kval[c] & q[c]);
        end
        3'h3:
        begin
          if (clk_edge[c] && dval[c] && !kval[c])
            next_q[c] = 1'b1;
          else if (clk_edge[c] && kval[c] && !dval[c])
            next_q[c] = 1'b0;
        end
        3'h4: next_q[c] = clk_lvl[c] ? dval[c] : q[c];
        default: next_q[c] = q[c];
      endcase
      // Reset wins over preset, both over the clock
      if (ar[c])
        next_q[c] = 1'b0;
      else if (ap[c])
        next_q[c] = 1'b1;
      case (cb[`PMC_B_OE_SEL])
        `PMC_OE_ON: oe_on[c] = 1'b1;
        `PMC_OE_PIN1: oe_on[c] = ~output_enable_n_first;
        `PMC_OE_PIN2: oe_on[c] = ~output_enable_n_second;
        `PMC_OE_TERM: oe_on[c] = pmc_pick(terms, cb[`PMC_B_OE_PT]);
        default: oe_on[c] = 1'b0;
      endcase
      if (c == `PMC_PD_CELL && dev_cfg[`PMC_DEV_PD_EN])
        oe_on[c] = 1'b0;
      fold[c] = ~pmc_pick(terms, cb[`PMC_B_FB_PT]);
      pin_out[c] = cb[`PMC_B_OUT_REG] ? q[c] : xo[c];
      // Buried register feedback also when a separate data term is used
      next_fb[c] = (cb[`PMC_B_OUT_REG] | ca[`PMC_A_D_SEL]) ? q[c] : xo[c];
    end
  end

  // Cell registers and outputs; all but the power-down and standby status hold in power-down
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      q <= 32'h0000_0000;
      clk_prev <= 32'h0000_0000;
      fb <= 32'h0000_0000;
      rbus <= 32'h0000_0000;
      o_io_pin <= 32'h0000_0000;
      o_io_oe_n <= 32'hFFFF_FFFF;
      act_snap <= 68'h0;
      o_standby <= 1'b0;
      o_power_down_active <= 1'b0;
    end
    else
    begin
      o_power_down_active <= frozen;
      if (!frozen)
      begin
        q <= next_q;
        clk_prev <= clk_lvl;
        fb <= next_fb;
        rbus <= fold;
        o_io_pin <= pin_out;
        o_io_oe_n <= ~oe_on;
      end
      // Standby is only reported; logic keeps running regardless
      act_snap <= {ded_val, io_val, q};
      o_standby <= (act_snap == {ded_val, io_val, q});
    end
  end

  // Configuration storage, written through the bus
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      dev_cfg <= `PMC_DEV_RESET;
      for (j = 0; j < `PMC_CELLS; j = j + 1)
      begin
        cell_a[j] <= `PMC_CFG_RESET;
        cell_b[j] <= `PMC_CFG_RESET;
      end
      for (j = 0; j < `PMC_MASK_WORDS; j = j + 1)
        mask_mem[j] <= `PMC_CFG_RESET;
    end
    else if (wr_en)
    begin
      case (wr_dec)
        `PMC_DEC_DEV: dev_cfg <= pmc_merge(dev_cfg, wdata_q, wstrb_q);
        `PMC_DEC_CELL:
        begin
          if (awaddr_q[2])
            cell_b[awaddr_q[7:3]] <= pmc_merge(cell_b[awaddr_q[7:3]], wdata_q, wstrb_q);
          else
            cell_a[awaddr_q[7:3]] <= pmc_merge(cell_a[awaddr_q[7:3]], wdata_q, wstrb_q);
        end
        `PMC_DEC_MASK:
          mask_mem[wr_mi[10:0]] <= pmc_merge(mask_mem[wr_mi[10:0]], wdata_q, wstrb_q);
        default: dev_cfg <= dev_cfg;
      endcase
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_axi_awready <= 1'b1;
      o_axi_wready <= 1'b1;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= `PMC_RESP_OKAY;
      awaddr_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (o_axi_awready && i_axi_awvalid)
      begin
        awaddr_q <= i_axi_awaddr;
        o_axi_awready <= 1'b0;
      end
      if (o_axi_wready && i_axi_wvalid)
      begin
        wdata_q <= i_axi_wdata;
        wstrb_q <= i_axi_wstrb;
        o_axi_wready <= 1'b0;
      end
      if (wr_en)
      begin
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= (wr_dec == `PMC_DEC_NONE) ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY;
      end
      // Ready returns only after the response is taken: one write in flight
      if (o_axi_bvalid && i_axi_bready)
      begin
        o_axi_bvalid <= 1'b0;
        o_axi_awready <= 1'b1;
        o_axi_wready <= 1'b1;
      end
    end
  end

  // Read data select
  always @*
  begin
    case (rd_dec)
      `PMC_DEC_DEV: rd_mux = dev_cfg;
      `PMC_DEC_STATUS: rd_mux = {30'h0, o_standby, o_power_down_active};
      `PMC_DEC_STATE: rd_mux = q;
      `PMC_DEC_PINS: rd_mux = o_io_pin;
      `PMC_DEC_CELL: rd_mux = i_axi_araddr[2] ? cell_b[i_axi_araddr[7:3]] :
        cell_a[i_axi_araddr[7:3]];
      `PMC_DEC_MASK: rd_mux = mask_mem[rd_mi[10:0]];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_axi_arready <= 1'b1;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= `PMC_RESP_OKAY;
    end
    else if (o_axi_arready && i_axi_arvalid)
    begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid <= 1'b1;
      o_axi_rdata <= rd_mux;
      o_axi_rresp <= (rd_dec == `PMC_DEC_NONE) ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY;
    end
    else if (o_axi_rvalid && i_axi_rready)
    begin
      o_axi_rvalid <= 1'b0;
      o_axi_arready <= 1'b1;
    end
  end

endmodule

//--- tb/pmc_device_props.sv
// Port-level checks for the macrocell device
`include "pmc_consts.vh"
module pmc_device_props (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_axi_awvalid,
  input wire o_axi_awready,
  input wire i_axi_wvalid,
  input wire o_axi_wready,
  input wire [1:0] o_axi_bresp,
  input wire o_axi_bvalid,
  input wire i_axi_bready,
  input wire i_axi_arvalid,
  input wire o_axi_arready,
  input wire [31:0] o_axi_rdata,
  input wire o_axi_rvalid,
  input wire i_axi_rready,
  input wire i_power_down_pin,
  input wire [31:0] o_io_pin,
  input wire [31:0] o_io_oe_n,
  input wire o_power_down_active,
  input wire o_standby
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Bus handshakes: latency and holding of answers
  chk_b_latency: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid
    && o_axi_wready |-> ##[2:3] o_axi_bvalid) else $error("write answer late");
  chk_b_hold: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid
    && $stable(o_axi_bresp)) else $error("write answer dropped");
  chk_one_write: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
    else $error("write taken while answer pending");
  chk_r_latency: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid
    && !o_axi_arready) else $error("read answer late");
  chk_r_hold: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid
    && $stable(o_axi_rdata)) else $error("read answer dropped");
  // Power-down entry, hold and exit
  chk_pd_needs_pin: assert property (
    (!i_power_down_pin) [*5] |-> !$rose(o_power_down_active)) else $error("pd without pin");
  chk_pd_release: assert property (
    (!i_power_down_pin) [*6] |-> !o_power_down_active) else $error("pd stuck");
  chk_pd_freeze: assert property (
    o_power_down_active && $past(o_power_down_active) |-> $stable(o_io_pin)
    && $stable(o_io_oe_n)) else $error("outputs moved in pd");
  chk_pd_cell_off: assert property (
    o_power_down_active |-> o_io_oe_n[31]) else $error("pd cell drives pin");
  // Reset must leave every output buffer off
  chk_oe_reset: assert property (
    disable iff (1'b0) !i_rst_n |=> &o_io_oe_n) else $error("buffer on after reset");
  cover property (o_power_down_active);
  cover property (o_standby);
  cover property (o_axi_bvalid && o_axi_bresp == `PMC_RESP_SLVERR);
endmodule
bind pmc_device pmc_device_props u_pmc_device_props (.*);

//--- tb/pmc_pin_drv.sv
// External logic driving the device's input and I/O pins
module pmc_pin_drv (
  input wire i_clk,
  input wire [3:0] i_ded_lvl,
  input wire i_pd_lvl,
  input wire [31:0] i_io_lvl,
  input wire [31:0] i_io_drv,
  input wire [31:0] i_dev_pin,
  input wire [31:0] i_dev_oe_n,
  output wire [3:0] o_ded_pin,
  output wire [3:0] o_ded_driven,
  output wire o_pd_pin,
  output wire [31:0] o_io_pin,
  output wire [31:0] o_io_driven
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [31:0] last = 32'h0000_0000;
  // Last wire level, so a floating wire drifts instead of keeping it
  always @(posedge i_clk)
    last <= o_io_pin;
  // Control pins; a low OE pin enables its outputs
  assign o_ded_pin = i_ded_lvl;
  assign o_ded_driven = 4'hF;
  assign o_pd_pin = i_pd_lvl;
  // Wire level from both parties' enables
  assign o_io_driven = i_io_drv | ~i_dev_oe_n;
  assign o_io_pin = (~i_dev_oe_n & i_dev_pin) | (i_dev_oe_n & i_io_drv & i_io_lvl)
    | (i_dev_oe_n & ~i_io_drv & ~last);
endmodule

//--- tb/pmc_device_tb_top.sv
// Self-checking bench: register bus access and pin behaviour of the device
`include "pmc_consts.vh"
module pmc_device_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [1:0] ok = `PMC_RESP_OKAY;
  localparam [1:0] se = `PMC_RESP_SLVERR;
  reg i_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg [15:0] aw_a = 16'h0000;
  reg [15:0] ar_a = 16'h0000;
  reg [31:0] w_d = 32'h0000_0000;
  reg awv = 1'b0;
  reg wv = 1'b0;
  reg bry = 1'b0;
  reg arv = 1'b0;
  reg rry = 1'b0;
  reg [3:0] ded = 4'hE;
  reg pd = 1'b0;
  reg [31:0] io = 32'h0000_0000;
  reg [31:0] drv = 32'hFFFF_FFFF;
  wire awrdy, wrdy, bvld, arrdy, rvld, pd_pin, pda, stby;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, io_pin, io_drvn, o_pin, oe_n;
  wire [3:0] ded_pin, ded_drv;
  int error_cnt = 0;
  int samples_checked = 0;

  pmc_device u_pmc_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi_awaddr(aw_a),
    .i_axi_awvalid(awv), .o_axi_awready(awrdy), .i_axi_wdata(w_d), .i_axi_wstrb(4'hF),
    .i_axi_wvalid(wv), .o_axi_wready(wrdy), .o_axi_bresp(bresp), .o_axi_bvalid(bvld),
    .i_axi_bready(bry), .i_axi_araddr(ar_a), .i_axi_arvalid(arv), .o_axi_arready(arrdy),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvld), .i_axi_rready(rry),
    .i_ded_pin(ded_pin), .i_ded_driven(ded_drv), .i_power_down_pin(pd_pin),
    .i_io_pin(io_pin), .i_io_driven(io_drvn), .o_io_pin(o_pin), .o_io_oe_n(oe_n),
    .o_power_down_active(pda), .o_standby(stby));
  pmc_pin_drv u_pmc_pin_drv (.i_clk(i_clk), .i_ded_lvl(ded), .i_pd_lvl(pd),
    .i_io_lvl(io), .i_io_drv(drv), .i_dev_pin(o_pin), .i_dev_oe_n(oe_n),
    .o_ded_pin(ded_pin), .o_ded_driven(ded_drv), .o_pd_pin(pd_pin),
    .o_io_pin(io_pin), .o_io_driven(io_drvn));

  initial
  begin
    forever #20 i_clk = ~i_clk;
  end

  task automatic results;
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address, data and response ready offered together, ready dropped once answer seen
  task automatic wr(input [15:0] a, input [31:0] d, input [1:0] er);
    @(posedge i_clk);
    aw_a <= a;
    w_d <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (!bvld);
    bry <= 1'b0;
    cmp(32'(bresp), 32'(er));
  endtask

  task automatic rd(input [15:0] a, input [31:0] exp, input [1:0] er);
    @(posedge i_clk);
    ar_a <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (arrdy) arv <= 1'b0;
    end
    while (!rvld);
    rry <= 1'b0;
    cmp(rdata, exp);
    cmp(32'(rresp), 32'(er));
  endtask

  // Pin changes need three sync edges plus cell and output registers
  task automatic st;
    repeat (8) @(posedge i_clk);
  endtask

  task automatic clk_pulse;
    ded[0] <= 1'b1;
    st;
    ded[0] <= 1'b0;
    st;
  endtask

  function automatic [15:0] pt(input int c, input int t);
    pt = 16'h1004 + 16'(32 * (c * 5 + t));
  endfunction

  function automatic [15:0] ca(input int c);
    ca = `PMC_ADDR_CELL_LO + 16'(8 * c);
  endfunction

  initial
  begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    results;
  end

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Register map edges
    rd(`PMC_ADDR_DEV, `PMC_DEV_RESET, ok);
    wr(16'h0010, 32'h0000_0001, se);
    rd(16'h0010, 32'h0000_0000, se);
    wr(`PMC_ADDR_STATUS, 32'h0000_0003, ok);
    // Cell 0: two pin terms summed, polarity from the XOR constant
    wr(pt(0, 0), 32'h0000_0100, ok);
    wr(pt(0, 1), 32'h0000_0200, ok);
    wr(ca(0) + 16'h0004, 32'h0000_0400, ok);
    for (int k = 0; k < 8; k++)
    begin
      wr(ca(0), k[2] ? 32'h0000_0043 : 32'h0000_0003, ok);
      io[9:8] <= k[1:0];
      st;
      cmp(32'(o_pin[0]), 32'((k[0] | k[1]) ^ k[2]));
      cmp(32'(oe_n[0]), 32'h0000_0000);
    end
    // Cell 1: registered D on the clock pin, enable and preset terms, clear pin
    wr(pt(1, 0), 32'h0000_0400, ok);
    wr(pt(1, 1), 32'h0000_0800, ok);
    wr(pt(1, 2), 32'h0000_1000, ok);
    wr(ca(1) + 16'h0004, 32'h0000_0601, ok);
    wr(ca(1), 32'h0000_0001, ok);
    io[10] <= 1'b1;
    st;
    cmp(32'(o_pin[1]), 32'h0000_0000);
    clk_pulse;
    cmp(32'(o_pin[1]), 32'h0000_0001);
    io[10] <= 1'b0;
    wr(ca(1), 32'h0600_0001, ok);
    clk_pulse;
    cmp(32'(o_pin[1]), 32'h0000_0001);
    io[11] <= 1'b1;
    clk_pulse;
    cmp(32'(o_pin[1]), 32'h0000_0000);
    io[10] <= 1'b1;
    clk_pulse;
    ded[1] <= 1'b0;
    st;
    cmp(32'(o_pin[1]), 32'h0000_0000);
    ded[1] <= 1'b1;
    wr(ca(1) + 16'h0004, 32'h0000_06A1, ok);
    io[12] <= 1'b1;
    st;
    cmp(32'(o_pin[1]), 32'h0000_0001);
    ded[1] <= 1'b0;
    st;
    cmp(32'(o_pin[1]), 32'h0000_0000);
    ded[1] <= 1'b1;
    io[12] <= 1'b0;
    // Toggle mode, then transparent latch
    wr(ca(1), 32'h0004_0001, ok);
    clk_pulse;
    cmp(32'(o_pin[1]), 32'h0000_0001);
    clk_pulse;
    cmp(32'(o_pin[1]), 32'h0000_0000);
    wr(ca(1), 32'h0010_0001, ok);
    ded[0] <= 1'b1;
    st;
    cmp(32'(o_pin[1]), 32'h0000_0001);
    ded[0] <= 1'b0;
    io[10] <= 1'b0;
    st;
    cmp(32'(o_pin[1]), 32'h0000_0001);
    // Cell 2 buffer on the first OE pin, active low
    wr(ca(2) + 16'h0004, 32'h0000_0800, ok);
    st;
    cmp(32'(oe_n[3:2]), 32'h0000_0003);
    ded[2] <= 1'b0;
    st;
    cmp(32'(oe_n[3:2]), 32'h0000_0002);
    ded[2] <= 1'b1;
    // Power-down freezes outputs until the pin falls
    io[9:8] <= 2'b00;
    wr(ca(31) + 16'h0004, 32'h0000_0400, ok);
    st;
    cmp(32'(oe_n[31]), 32'h0000_0000);
    wr(`PMC_ADDR_DEV, 32'h0000_03E4, ok);
    pd <= 1'b1;
    st;
    cmp(32'(pda), 32'h0000_0001);
    cmp(32'(oe_n[31]), 32'h0000_0001);
    io[8] <= 1'b1;
    st;
    cmp(32'(o_pin[0]), 32'h0000_0001);
    pd <= 1'b0;
    st;
    cmp({31'(pda), o_pin[0]}, 32'h0000_0000);
    wr(`PMC_ADDR_DEV, `PMC_DEV_RESET, ok);
    pd <= 1'b1;
    st;
    cmp(32'(pda), 32'h0000_0000);
    pd <= 1'b0;
    // Keeper holds a released pin high; without it the pin reads low
    drv[8] <= 1'b0;
    st;
    cmp(32'(o_pin[0]), 32'h0000_0000);
    wr(`PMC_ADDR_DEV, 32'h0000_00E4, ok);
    st;
    cmp(32'(o_pin[0]), 32'h0000_0001);
    drv[8] <= 1'b1;
    wr(`PMC_ADDR_DEV, `PMC_DEV_RESET, ok);
    // Quiet device reports standby
    st;
    cmp(32'(stby), 32'h0000_0001);
    rd(`PMC_ADDR_STATUS, 32'h0000_0002, ok);
    results;
  end
endmodule
